// [supervisor_defines.svh]
// offsets, field positions, reset values and timing of the power supervisor
// assumes byte addresses on a 12-bit register port, 100 MHz sys_clk
`ifndef SUPERVISOR_DEFINES_SVH
`define SUPERVISOR_DEFINES_SVH

// ****************************************
// register offsets
// ****************************************
`define ADDR_WAKE_CAUSE 12'h000
`define ADDR_HS_CTRL    12'h05C
`define ADDR_FAIL_STS   12'h070
`define ADDR_GP_CNF     12'h07C
`define ADDR_CTRL       12'h080
`define ADDR_RST_CAUSE  12'h084
`define REG_RESET       32'h00000000

// ****************************************
// field positions
// ****************************************
`define FAIL_SHORT      0
`define FAIL_TMOUT      1
`define FAIL_CORE_OVL   2
`define FAIL_PAD_OVL    3
`define FAIL_CLK        4
`define FAIL_OT         5
`define FAIL_WDT_SEQ    6
`define FAIL_LP_CLK     7
`define HS1_CYC_BIT     2
`define HS2_CYC_BIT     10
`define GP_SEL_BIT      0
`define CTRL_SLEEP_BIT  0
`define CTRL_STOP_BIT   1
`define RST_SYS_FAIL    0
`define RST_HARD        1
`define RST_WAKE        2
`define WAKE_LIN        0
`define WAKE_MON        1
`define WAKE_EXT_OT     17
`define WAKE_EXT_UV     18

// ****************************************
// timing
// ****************************************
`define CLK_NS          10
`define OVL_FILTER_NS   290000
`define STARTUP_NS      100000
`define CPU_RST_NS      1000
`define FAIL_LIMIT      5

`endif

// [supervisor_pkg.sv]
// types shared by the power supervisor modules
// assumes nothing beyond a SystemVerilog compiler
package supervisor_pkg;

  // one-hot power modes
  typedef enum logic [3:0] {
    MODE_STARTUP = 4'h1,
    MODE_ACTIVE  = 4'h2,
    MODE_SLEEP   = 4'h4,
    MODE_STOP    = 4'h8
  } mode_t;

endpackage : supervisor_pkg

// [fail_count_if.sv]
// carrier between the supervisor and its failure counters
// assumes both ends share sys_clk
`timescale 1ns/1ps
`default_nettype none
interface fail_count_if #(parameter int unsigned CW = 3);
  logic          inc;
  logic          clr;
  logic          last;
  logic [CW-1:0] count;
  modport owner   (output inc, output clr, input count, input last);
  modport counter (input inc, input clr, output count, output last);
endinterface : fail_count_if
`default_nettype wire

// [fail_counter.sv]
// saturating failure counter with clear, used for supply and watchdog faults
// assumes inc and clr come from logic on sys_clk
`timescale 1ns/1ps
`default_nettype none
`include "supervisor_defines.svh"
module fail_counter #(
  parameter int unsigned LIMIT = `FAIL_LIMIT,
  parameter int unsigned CW    = 3
) (
  input wire logic     sys_clk,
  input wire logic     rst_b,
  fail_count_if.counter cnt
);
  typedef struct packed {
    logic [CW-1:0] count;
  } cnt_st_t;

  cnt_st_t st_r;
  cnt_st_t st_nxt;

  if (LIMIT < 1 || LIMIT >= 2 ** CW) begin : g_bad_limit
    $error("fail limit does not fit the counter");
  end

  // clear beats increment so a count cleared on a mode change always starts from zero
  always_comb begin
    st_nxt = st_r;
    if (cnt.clr) begin
      st_nxt.count = '0;
    end else if (cnt.inc && st_r.count != CW'(LIMIT)) begin
      st_nxt.count = st_r.count + 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign cnt.count = st_r.count;
  assign cnt.last  = (st_r.count == CW'(LIMIT - 1));
endmodule : fail_counter
`default_nettype wire

// [power_supervisor.sv]
// fail-safe power supervisor: mode sequencing, fault counting, fail status
// assumes regulator, watchdog and wake inputs are asynchronous pins
`timescale 1ns/1ps
`default_nettype none
`include "supervisor_defines.svh"
// How it works
// - regulator malfunction restarts regulators, counts once
// - fifth supply fault sends system to Sleep
// - supply-count Sleep leaves timeout flag set
// - startup short: hold reset, count, retry
// - watchdog fault resets CPU, stays Active
// - fifth watchdog fault enters Sleep, LIN/monitor wake
// - Sleep or Stop command clears watchdog count
// - regulator overcurrent: Sleep and overload flag
// - overload must persist 290 us first
// - external regulator error wakes from Stop
// - reset pin wakes Stop, pin follows CPU reset
// - pin wake logs hard and wake reset
// - regulator fail in Stop: Active, then restart
// - fail bit 6 on watchdog sequence fail
// - fail bit 5 on system overtemperature
// - fail bit 4 on system clock failure
// - fail bits 3/2 on pad/core overload
// - fail bits 1/0 supply timeout and short
// - clearing system-fail bit clears fail register
// - high-side cyclic enables at bits 10, 2
// - purpose select bit 0; write clears data
module power_supervisor #(
  parameter int unsigned NMON           = 4,
  parameter int unsigned TW             = 16,
  parameter int unsigned OVL_FILTER_CYC = (`OVL_FILTER_NS + `CLK_NS - 1) / `CLK_NS,
  parameter int unsigned STARTUP_CYC    = (`STARTUP_NS + `CLK_NS - 1) / `CLK_NS
) (
  input  wire logic            sys_clk,
  input  wire logic            rst_b,
  input  wire logic [11:0]     addr,
  input  wire logic [31:0]     wdata,
  input  wire logic            wr_en,
  input  wire logic            rd_en,
  output logic      [31:0]     rdata,
  input  wire logic            supply_malfunction,
  input  wire logic            supply_short_det,
  input  wire logic            supply_stable,
  input  wire logic            pad_overload_det,
  input  wire logic            core_overload_det,
  input  wire logic            watchdog_fail,
  input  wire logic            sys_overtemp_det,
  input  wire logic            sys_clock_fail,
  input  wire logic            low_power_clock_fail,
  input  wire logic            ext_overtemp_det,
  input  wire logic            ext_undervolt_det,
  input  wire logic            lin_wake,
  input  wire logic [NMON-1:0] hv_sense_input,
  input  wire logic            reset_pin_in,
  output logic                 reset_pin_out,
  output logic                 reset_pin_oe_b,
  output logic                 cpu_rst_b,
  output logic                 regulator_restart,
  output logic      [3:0]      power_mode,
  output logic                 high_side_one_cyclic_enable,
  output logic                 high_side_two_cyclic_enable,
  output logic                 gp_purpose_sel,
  output logic                 gp_data_clear
);
  localparam int unsigned CPU_RST_CYC = (`CPU_RST_NS + `CLK_NS - 1) / `CLK_NS;
  localparam int unsigned IN_W = 13 + NMON;
  localparam int I_MAL = 0, I_SHORT = 1, I_STABLE = 2, I_PAD = 3, I_CORE = 4;
  localparam int I_WDT = 5, I_OT = 6, I_CLK = 7, I_LP = 8, I_EOT = 9;
  localparam int I_EUV = 10, I_LIN = 11, I_RSTN = 12, I_MON = 13;
  localparam supervisor_pkg::mode_t M_SU  = supervisor_pkg::MODE_STARTUP;
  localparam supervisor_pkg::mode_t M_ACT = supervisor_pkg::MODE_ACTIVE;
  localparam supervisor_pkg::mode_t M_SLP = supervisor_pkg::MODE_SLEEP;
  localparam supervisor_pkg::mode_t M_STP = supervisor_pkg::MODE_STOP;

  if (STARTUP_CYC < 1 || STARTUP_CYC >= 2 ** TW ||
      OVL_FILTER_CYC < 2 || OVL_FILTER_CYC >= 2 ** TW || NMON < 1) begin : g_bad
    $error("timing counts do not fit the timer width");
  end

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [IN_W-1:0]       s1;
    logic [IN_W-1:0]       s2;
    logic [IN_W-1:0]       s3;
    logic [IN_W-1:0]       filt;
    logic [IN_W-1:0]       prev;
    supervisor_pkg::mode_t mode;
    logic [TW-1:0]         timer;
    logic [TW-1:0]         ovl_cnt;
    logic                  rst_drv;
    logic                  cpu_rst_b;
    logic                  pin_oe_b;
    logic [6:0]            fail;
    logic [2:0]            rst_cause;
    logic [3:0]            wake;
    logic                  hs1;
    logic                  hs2;
    logic                  gp_sel;
    logic                  gp_clr;
    logic                  restart;
    logic [31:0]           rdata;
  } st_t;

  st_t st_r;
  st_t st_nxt;

  fail_count_if #(.CW(3)) sup_if ();
  fail_count_if #(.CW(3)) wdt_if ();

  fail_counter #(.LIMIT(`FAIL_LIMIT), .CW(3)) u_supply_cnt (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .cnt     (sup_if.counter)
  );

  fail_counter #(.LIMIT(`FAIL_LIMIT), .CW(3)) u_wdt_cnt (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .cnt     (wdt_if.counter)
  );

  function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
    return a == o;
  endfunction : hit

  logic [IN_W-1:0] pins;
  logic [IN_W-1:0] lvl;
  logic [IN_W-1:0] rise;
  logic [IN_W-1:0] fall;
  logic [IN_W-1:0] agree;
  logic            sup_inc;
  logic            sup_clr;
  logic            wdt_inc;
  logic            wdt_clr;
  logic            ovl_trip;
  logic            to_sleep;
  logic            cmd_sleep;
  logic            cmd_stop;
  logic            wclr;
  logic [2:0]      rclr;
  logic [6:0]      fset;
  logic [2:0]      rset;
  logic [3:0]      wset;
  logic [31:0]     rv;

  assign pins = {hv_sense_input, reset_pin_in, lin_wake, ext_undervolt_det,
                 ext_overtemp_det, low_power_clock_fail, sys_clock_fail,
                 sys_overtemp_det, watchdog_fail, core_overload_det,
                 pad_overload_det, supply_stable, supply_short_det,
                 supply_malfunction};
  assign lvl  = st_r.filt;
  assign rise = st_r.filt & ~st_r.prev;
  assign fall = ~st_r.filt & st_r.prev;

  assign sup_if.inc = sup_inc;
  assign sup_if.clr = sup_clr;
  assign wdt_if.inc = wdt_inc;
  assign wdt_if.clr = wdt_clr;

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    st_nxt    = st_r;
    sup_inc   = 1'b0;
    sup_clr   = 1'b0;
    wdt_inc   = 1'b0;
    wdt_clr   = 1'b0;
    ovl_trip  = 1'b0;
    to_sleep  = 1'b0;
    cmd_sleep = 1'b0;
    cmd_stop  = 1'b0;
    fset      = '0;
    rset      = '0;
    wset      = '0;
    rv        = `REG_RESET;
    // three-stage sync; a level counts once stages two and three agree
    agree        = ~(st_r.s2 ^ st_r.s3);
    st_nxt.s1    = pins;
    st_nxt.s2    = st_r.s1;
    st_nxt.s3    = st_r.s2;
    st_nxt.filt  = (st_r.filt & ~agree) | (st_r.s3 & agree);
    st_nxt.prev  = st_r.filt;
    st_nxt.gp_clr  = 1'b0;
    st_nxt.restart = 1'b0;
    st_nxt.rdata   = `REG_RESET;
    if (st_r.timer != '0) begin
      st_nxt.timer = st_r.timer - 1'b1;
    end

    if (wr_en && hit(addr, `ADDR_HS_CTRL)) begin
      st_nxt.hs1 = wdata[`HS1_CYC_BIT];
      st_nxt.hs2 = wdata[`HS2_CYC_BIT];
    end
    if (wr_en && hit(addr, `ADDR_GP_CNF)) begin
      st_nxt.gp_sel = wdata[`GP_SEL_BIT];
      st_nxt.gp_clr = 1'b1;
    end
    if (wr_en && hit(addr, `ADDR_CTRL)) begin
      cmd_sleep = wdata[`CTRL_SLEEP_BIT];
      cmd_stop  = wdata[`CTRL_STOP_BIT];
    end
    rclr = (wr_en && hit(addr, `ADDR_RST_CAUSE)) ? wdata[2:0] : 3'h0;
    wclr = rd_en && hit(addr, `ADDR_WAKE_CAUSE);

    // overload must hold for the whole filter before it counts
    if (st_r.mode == M_ACT && (lvl[I_PAD] || lvl[I_CORE])) begin
      if (st_r.ovl_cnt == TW'(OVL_FILTER_CYC - 1)) begin
        ovl_trip = 1'b1;
      end else begin
        st_nxt.ovl_cnt = st_r.ovl_cnt + 1'b1;
      end
    end else begin
      st_nxt.ovl_cnt = '0;
    end

    case (st_r.mode)
      M_SU: begin
        st_nxt.rst_drv = 1'b1;
        if (rise[I_SHORT] || st_r.timer == '0) begin
          if (!rise[I_SHORT] && lvl[I_STABLE] && !lvl[I_SHORT]) begin
            st_nxt.mode    = M_ACT;
            st_nxt.rst_drv = 1'b0;
          end else begin
            sup_inc              = 1'b1;
            st_nxt.restart       = 1'b1;
            st_nxt.timer         = TW'(STARTUP_CYC);
            fset[`FAIL_SHORT]    = lvl[I_SHORT];
            fset[`FAIL_TMOUT]    = !lvl[I_SHORT] || sup_if.last;
            to_sleep             = sup_if.last;
          end
        end
      end
      M_ACT: begin
        if (st_r.rst_drv && st_r.timer == '0) begin
          st_nxt.rst_drv = 1'b0;
        end
        if (lvl[I_MAL]) begin
          sup_inc        = 1'b1;
          st_nxt.restart = 1'b1;
          if (sup_if.last) begin
            to_sleep          = 1'b1;
            fset[`FAIL_TMOUT] = 1'b1;
          end else begin
            st_nxt.mode    = M_SU;
            st_nxt.rst_drv = 1'b1;
            st_nxt.timer   = TW'(STARTUP_CYC);
          end
        end else if (ovl_trip) begin
          to_sleep             = 1'b1;
          fset[`FAIL_PAD_OVL]  = lvl[I_PAD];
          fset[`FAIL_CORE_OVL] = lvl[I_CORE];
        end else if (rise[I_WDT]) begin
          wdt_inc = 1'b1;
          if (wdt_if.last) begin
            to_sleep             = 1'b1;
            fset[`FAIL_WDT_SEQ]  = 1'b1;
          end else begin
            st_nxt.rst_drv = 1'b1;
            st_nxt.timer   = TW'(CPU_RST_CYC);
          end
        end else if (cmd_sleep) begin
          to_sleep = 1'b1;
        end else if (cmd_stop) begin
          st_nxt.mode    = M_STP;
          st_nxt.rst_drv = 1'b0;
        end
      end
      M_SLP: begin
        st_nxt.rst_drv = 1'b1;
        // only LIN and monitor edges can end Sleep
        if (rise[I_LIN] || (st_r.filt[IN_W-1:I_MON] != st_r.prev[IN_W-1:I_MON])) begin
          st_nxt.mode      = M_SU;
          st_nxt.timer     = TW'(STARTUP_CYC);
          sup_clr          = 1'b1;
          wset[`WAKE_LIN]  = rise[I_LIN];
          wset[`WAKE_MON]  = !rise[I_LIN];
        end
      end
      M_STP: begin
        if (fall[I_RSTN]) begin
          st_nxt.mode      = M_ACT;
          st_nxt.rst_drv   = 1'b1;
          st_nxt.timer     = TW'(CPU_RST_CYC);
          rset[`RST_HARD]  = 1'b1;
          rset[`RST_WAKE]  = 1'b1;
        end else if (rise[I_EOT] || rise[I_EUV]) begin
          st_nxt.mode = M_ACT;
          wset[2]     = rise[I_EOT];
          wset[3]     = rise[I_EUV];
        end else if (lvl[I_MAL]) begin
          // restart and count follow from the Active branch next cycle
          st_nxt.mode = M_ACT;
        end else if (rise[I_LIN] || (st_r.filt[IN_W-1:I_MON] != st_r.prev[IN_W-1:I_MON])) begin
          st_nxt.mode     = M_ACT;
          wset[`WAKE_LIN] = rise[I_LIN];
          wset[`WAKE_MON] = !rise[I_LIN];
        end
      end
      default: begin
        st_nxt.mode    = M_SU;
        st_nxt.rst_drv = 1'b1;
      end
    endcase

    if (to_sleep) begin
      st_nxt.mode    = M_SLP;
      st_nxt.rst_drv = 1'b1;
    end
    // each Active period counts watchdog faults afresh
    if (st_r.mode == M_ACT && st_nxt.mode != M_ACT) begin
      wdt_clr = 1'b1;
    end

    fset[`FAIL_OT]  = lvl[I_OT];
    fset[`FAIL_CLK] = lvl[I_CLK];
    rset[`RST_SYS_FAIL] = |fset;
    // sets win over clears
    st_nxt.fail = (rclr[`RST_SYS_FAIL] ? 7'h00 : st_r.fail) | fset;
    st_nxt.rst_cause = (st_r.rst_cause & ~rclr) | rset;
    st_nxt.wake      = (wclr ? 4'h0 : st_r.wake) | wset;
    st_nxt.cpu_rst_b = ~st_nxt.rst_drv;
    st_nxt.pin_oe_b  = ~st_nxt.rst_drv;

    // unmapped and reserved bits read as zero
    if (hit(addr, `ADDR_WAKE_CAUSE)) begin
      rv[`WAKE_LIN]    = st_r.wake[0];
      rv[`WAKE_MON]    = st_r.wake[1];
      rv[`WAKE_EXT_OT] = st_r.wake[2];
      rv[`WAKE_EXT_UV] = st_r.wake[3];
    end else if (hit(addr, `ADDR_HS_CTRL)) begin
      rv[`HS1_CYC_BIT] = st_r.hs1;
      rv[`HS2_CYC_BIT] = st_r.hs2;
    end else if (hit(addr, `ADDR_FAIL_STS)) begin
      rv[6:0]          = st_r.fail;
      rv[`FAIL_LP_CLK] = lvl[I_LP];
    end else if (hit(addr, `ADDR_GP_CNF)) begin
      rv[`GP_SEL_BIT]  = st_r.gp_sel;
    end else if (hit(addr, `ADDR_CTRL)) begin
      rv[7:4]          = st_r.mode;
    end else if (hit(addr, `ADDR_RST_CAUSE)) begin
      rv[2:0]          = st_r.rst_cause;
    end
    if (rd_en) begin
      st_nxt.rdata = rv;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_r           <= '0;
      st_r.mode      <= M_SU;
      st_r.timer     <= TW'(STARTUP_CYC);
      st_r.rst_drv   <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign rdata                       = st_r.rdata;
  assign reset_pin_out               = 1'b0;
  assign reset_pin_oe_b              = st_r.pin_oe_b;
  assign cpu_rst_b                   = st_r.cpu_rst_b;
  assign regulator_restart           = st_r.restart;
  assign power_mode                  = st_r.mode;
  assign high_side_one_cyclic_enable = st_r.hs1;
  assign high_side_two_cyclic_enable = st_r.hs2;
  assign gp_purpose_sel              = st_r.gp_sel;
  assign gp_data_clear               = st_r.gp_clr;

  // ****************************************
  // checks
  // ****************************************
  property p_mal_restart;
    @(posedge sys_clk) disable iff (!rst_b)
      (st_r.mode == M_ACT && lvl[I_MAL] && !sup_if.last)
        |=> (regulator_restart && power_mode == M_SU && !cpu_rst_b);
  endproperty
  a_mal_restart: assert property (p_mal_restart) else $error("no restart on fault");

  property p_supply_sleep;
    @(posedge sys_clk) disable iff (!rst_b)
      (sup_inc && sup_if.last) |=> (power_mode == M_SLP && st_r.fail[`FAIL_TMOUT]);
  endproperty
  a_supply_sleep: assert property (p_supply_sleep) else $error("no sleep at limit");

  property p_wdt_reset;
    @(posedge sys_clk) disable iff (!rst_b)
      (wdt_inc && !wdt_if.last) |=> (power_mode == M_ACT && !cpu_rst_b) [*2];
  endproperty
  a_wdt_reset: assert property (p_wdt_reset) else $error("watchdog reset wrong");

  property p_wdt_sleep;
    @(posedge sys_clk) disable iff (!rst_b)
      (wdt_inc && wdt_if.last) |=> (power_mode == M_SLP && st_r.fail[`FAIL_WDT_SEQ]);
  endproperty
  a_wdt_sleep: assert property (p_wdt_sleep) else $error("no sleep on wdt");

  property p_cmd_clear;
    @(posedge sys_clk) disable iff (!rst_b)
      (st_r.mode == M_ACT && (power_mode != st_nxt.mode)) |=> (wdt_if.count == 3'h0);
  endproperty
  a_cmd_clear: assert property (p_cmd_clear) else $error("wdt count kept");

  property p_ovl_filter;
    @(posedge sys_clk) disable iff (!rst_b)
      $rose(ovl_trip) |-> $past(st_r.ovl_cnt, 2) == TW'(OVL_FILTER_CYC - 3);
  endproperty
  a_ovl_filter: assert property (p_ovl_filter) else $error("overload filter short");

  property p_pin_follows;
    @(posedge sys_clk) disable iff (!rst_b)
      (reset_pin_oe_b == cpu_rst_b) && !reset_pin_out;
  endproperty
  a_pin_follows: assert property (p_pin_follows) else $error("pin not tied to reset");

  property p_pin_wake;
    @(posedge sys_clk) disable iff (!rst_b)
      (st_r.mode == M_STP && fall[I_RSTN])
        |=> (power_mode == M_ACT && st_r.rst_cause[`RST_HARD] && st_r.rst_cause[`RST_WAKE]);
  endproperty
  a_pin_wake: assert property (p_pin_wake) else $error("pin wake not logged");

  property p_fail_clear;
    @(posedge sys_clk) disable iff (!rst_b)
      (rclr[`RST_SYS_FAIL] && fset == 7'h00) |=> (st_r.fail == 7'h00);
  endproperty
  a_fail_clear: assert property (p_fail_clear) else $error("fail reg not cleared");

  property p_gp_clear;
    @(posedge sys_clk) disable iff (!rst_b)
      (wr_en && hit(addr, `ADDR_GP_CNF)) ##1 !(wr_en && hit(addr, `ADDR_GP_CNF))
        |-> (gp_data_clear ##1 !gp_data_clear);
  endproperty
  a_gp_clear: assert property (p_gp_clear) else $error("no data clear pulse");
endmodule : power_supervisor
`default_nettype wire

// [supply_partner.sv]
// partner: main regulators and the open-drain reset pin
// assumes the bench clock; the pin has a pull-up
`timescale 1ns/1ps
`default_nettype none
module supply_partner (
  input  wire logic sys_clk,
  input  wire logic hold_bad,
  input  wire logic ext_req_b,
  input  wire logic regulator_restart,
  input  wire logic pin_drv,
  input  wire logic pin_oe_b,
  output logic      supply_stable,
  output logic      pin_level
);
  logic [2:0] ramp_r = 3'h0;

  // regulators settle a few cycles after each restart
  always_ff @(posedge sys_clk) begin
    if (regulator_restart)
      ramp_r <= 3'h0;
    else if (ramp_r != 3'h5)
      ramp_r <= ramp_r + 3'h1;
  end
  assign supply_stable = !hold_bad && (ramp_r == 3'h5);
  // pull-up wins once every driver lets go
  assign pin_level = ext_req_b & (pin_oe_b | pin_drv);
endmodule : supply_partner
`default_nettype wire

// [test_power_supervisor.sv]
// bench for the power supervisor: register port and fail-safe flows
// assumes short startup and overload filter counts
`timescale 1ns/1ps
`default_nettype none
module test_power_supervisor;
  logic        sys_clk, rst_b, wr_en, rd_en, reset_pin_in, reset_pin_out, reset_pin_oe_b;
  logic [11:0] addr;
  logic [31:0] wdata, rdata;
  logic        supply_stable, pad_ovl, wd, ot, ck, lpc, uv, lin, bad, req_b, mal, shrt, eot;
  logic [3:0]  hv, power_mode;
  logic        cpu_rst_b, regulator_restart, hs1, hs2, gp_purpose_sel, gp_data_clear;
  int          err_count, cmp_count, cyc, rr_cnt;

  power_supervisor #(.OVL_FILTER_CYC(8), .STARTUP_CYC(20)) u_dut (
    .sys_clk, .rst_b, .addr, .wdata, .wr_en, .rd_en, .rdata,
    .supply_malfunction(mal), .supply_short_det(shrt), .supply_stable,
    .pad_overload_det(pad_ovl), .core_overload_det(1'b0), .watchdog_fail(wd),
    .sys_overtemp_det(ot), .sys_clock_fail(ck), .low_power_clock_fail(lpc),
    .ext_overtemp_det(eot), .ext_undervolt_det(uv), .lin_wake(lin),
    .hv_sense_input(hv), .reset_pin_in, .reset_pin_out, .reset_pin_oe_b,
    .cpu_rst_b, .regulator_restart, .power_mode,
    .high_side_one_cyclic_enable(hs1), .high_side_two_cyclic_enable(hs2),
    .gp_purpose_sel, .gp_data_clear);

  supply_partner u_far (.sys_clk, .hold_bad(bad), .ext_req_b(req_b), .regulator_restart,
    .pin_drv(reset_pin_out), .pin_oe_b(reset_pin_oe_b), .supply_stable,
    .pin_level(reset_pin_in));

  // ****************************************
  // tasks
  // ****************************************
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask : chk

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    addr  <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge sys_clk);
    wr_en <= 1'b0;
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    @(posedge sys_clk);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge sys_clk);
    rd_en <= 1'b0;
    #1;
    chk("rdata", e, rdata);
    @(posedge sys_clk);
  endtask : rd

  // bounded wait for a mode, then compare
  // looks only off the edge, returns on an edge so stimulus stays edge-aligned
  task automatic wm(input logic [3:0] m, input int n);
    #1;
    for (int i = 0; i < n && power_mode !== m; i++) begin
      @(posedge sys_clk);
      #1;
    end
    chk("power_mode", m, power_mode);
    @(posedge sys_clk);
  endtask : wm

  // one missed watchdog service; reset pulse outlasts 100 cycles
  task automatic wdf(input logic [3:0] m);
    @(posedge sys_clk);
    wd <= 1'b1;
    repeat (8) @(posedge sys_clk);
    wd <= 1'b0;
    #1;
    chk("cpu_rst_b", 0, cpu_rst_b);
    chk("power_mode", m, power_mode);
    repeat (120) @(posedge sys_clk);
  endtask : wdf

  task automatic wrap_up;
    $display("compares %0d errors %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : wrap_up

  // ****************************************
  // clock, watchdog of the run
  // ****************************************
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc++;
    if (regulator_restart === 1'b1) rr_cnt++;
    if (cyc == 20000) begin
      err_count++;
      wrap_up();
    end
  end

  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    {rst_b, wr_en, rd_en, pad_ovl, wd, ot, ck, lpc, uv, lin, bad, mal, shrt, eot} <= '0;
    {addr, wdata, hv} <= '0;
    req_b <= 1'b1;
    repeat (8) @(posedge sys_clk);
    chk("power_mode", 4'h1, power_mode);
    rst_b <= 1'b1;
    wm(4'h2, 200);
    rd(12'h05C, 0);
    rd(12'h070, 0);
    rd(12'h07C, 0);
    rd(12'h100, 0);
    wr(12'h05C, 32'hFFFFFFFF);
    rd(12'h05C, 32'h404);
    chk("hs_enables", 2'h3, {hs2, hs1});
    wr(12'h07C, 32'hFFFFFFFF);
    #1;
    chk("gp_data_clear", 1, gp_data_clear);
    rd(12'h07C, 1);
    for (int k = 0; k < 4; k++) wdf(4'h2);
    wr(12'h080, 2);
    wm(4'h8, 10);
    req_b <= 1'b0;
    repeat (8) @(posedge sys_clk);
    req_b <= 1'b1;
    wm(4'h2, 10);
    #1;
    chk("pin_level", 0, reset_pin_in);
    rd(12'h084, 6);
    repeat (150) @(posedge sys_clk);
    #1;
    chk("pin_rel", 2'h3, {reset_pin_in, cpu_rst_b});
    wr(12'h084, 6);
    wr(12'h080, 2);
    wm(4'h8, 10);
    {uv, eot} <= 2'h3;
    wm(4'h2, 20);
    {uv, eot} <= 2'h0;
    rd(12'h000, 32'h60000);
    repeat (120) @(posedge sys_clk);
    for (int k = 1; k <= 5; k++) wdf(k < 5 ? 4'h2 : 4'h4);
    rd(12'h070, 32'h40);
    lin <= 1'b1;
    wm(4'h2, 300);
    lin <= 1'b0;
    wr(12'h084, 1);
    rd(12'h070, 0);
    {ot, ck, lpc} <= 3'h7;
    repeat (10) @(posedge sys_clk);
    rd(12'h070, 32'hB0);
    {ot, ck, lpc} <= 3'h0;
    repeat (6) @(posedge sys_clk);
    wr(12'h084, 1);
    rd(12'h070, 0);
    pad_ovl <= 1'b1;
    repeat (6) @(posedge sys_clk);
    #1;
    chk("power_mode", 4'h2, power_mode);
    wm(4'h4, 30);
    pad_ovl <= 1'b0;
    hv <= 4'h1;
    wm(4'h2, 300);
    rd(12'h070, 32'h8);
    rd(12'h000, 32'h3);
    wr(12'h080, 2);
    wm(4'h8, 10);
    rr_cnt = 0;
    // two-cycle fault: seen once in Stop, counted once in Active
    mal <= 1'b1;
    repeat (2) @(posedge sys_clk);
    mal <= 1'b0;
    wm(4'h1, 10);
    wm(4'h2, 60);
    chk("restarts", 1, rr_cnt);
    wr(12'h080, 1);
    wm(4'h4, 10);
    hv <= 4'h0;
    wm(4'h2, 300);
    {bad, shrt} <= 2'h3;
    rst_b <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rr_cnt = 0;
    rst_b <= 1'b1;
    wm(4'h4, 400);
    #1;
    chk("restarts", 5, rr_cnt);
    rd(12'h070, 32'h3);
    {bad, shrt} <= 2'h0;
    hv <= 4'h1;
    wm(4'h2, 300);
    wrap_up();
  end
endmodule : test_power_supervisor
`default_nettype wire
